// >>> hdl/smp_map.svh
// Constants for the serial memory programming port: command fields, sizes and timing.
// Assumes inclusion by both link ends and the package; holds definitions only.
`ifndef SMP_MAP_SVH
`define SMP_MAP_SVH
`define SMP_WORD_BITS      32
`define SMP_BIT_DATA_SEL   29
`define SMP_BIT_CODE_SEL   28
`define SMP_BIT_READ       24
`define SMP_ADDR_HI        18
`define SMP_ADDR_LO        8
`define SMP_DATA_HI        7
`define SMP_DATA_LO        0
`define SMP_ADDR_BITS      11
`define SMP_DATA_DEPTH     2048
`define SMP_CODE_DEPTH     2048
`define SMP_BUSY_NS        400
`define SMP_CLK_NS         20
`define SMP_BUSY_CYC       ((`SMP_BUSY_NS + `SMP_CLK_NS - 1) / `SMP_CLK_NS)
`define SMP_HALF_CYC       4
`define SMP_CNT_W          6
`endif

// >>> hdl/smp_pkg.sv
// Types shared by both ends of the serial memory programming port.
// Assumes smp_map.svh is on the include path.
`include "smp_map.svh"
package smp_pkg;
	typedef enum logic [1:0] {SMP_DEV_IDLE, SMP_DEV_SHIFT, SMP_DEV_EXEC, SMP_DEV_DONE} smp_dev_st_t;
	typedef enum logic [2:0] {SMP_PRG_IDLE, SMP_PRG_SHIFT, SMP_PRG_LOW, SMP_PRG_PULSE,
		SMP_PRG_WAIT, SMP_PRG_RISE} smp_prg_st_t;
endpackage : smp_pkg

// >>> hdl/smp_link_if.sv
// Five-wire programming link between a programmer and the device.
// Assumes both ends share no clock; every wire is a plain level.
`timescale 1ns/1ps
interface smp_link_if;
	logic hv_mode;    // Super voltage level seen on the strobe pin.
	logic load;       // Strobe at logic level: high shifts, low commits.
	logic sdi;        // Serial data into the device.
	logic sdo;        // Serial data out of the device.
	logic sclk;       // Serial clock made by the programmer.
	modport device (input hv_mode, input load, input sdi, input sclk, output sdo);
	modport programmer (output hv_mode, output load, output sdi, output sclk, input sdo);
endinterface : smp_link_if

// >>> hdl/smp_device.sv
// Device end of the serial memory programming port with its data and code memories.
// Assumes the link wires are asynchronous and are synchronised on mclk_in.
// Operation
// (RL1) Programmer reaches data, code and init memories; the code holds data and code memories only, with no init memory
// (RL2) Four pins: strobe, in, out, clock
// (RL3) Super voltage on strobe enters programming
// (RL4) Strobe held high while command shifts in
// (RL5) Words move most significant bit first
// (RL6) Previous response shifts out while command enters
// (RL7) First response after entry is undefined
// (RL8) Strobe low, then two clocks execute
// (RL9) Output low by second clock while strobe low
// (RL10) Ready status bit set when write finishes
// (RL11) Output returns high once operation completes
// (RL12) Programmer waits for high output before next
// (RL13) Read byte loads into response low byte
// (RL14) Unused command bits are driven zero
// (RL15) Bit 29 selects data memory and init; the code selects data memory only
// (RL16) Bit 28 selects code memory
// (RL17) Bit 24 high reads, low writes
// (RL18) Bits 18 to 8 hold address
// (RL19) Bits 7 to 0 hold write data
// (RL20) Response echoes the address field
// (RL21) Response low byte holds written or read byte
// (RL22) Link addresses equal normal operation addresses
`timescale 1ns/1ps
`include "smp_map.svh"
module smp_device
	import smp_pkg::*;
#(
	parameter int DATA_DEPTH = `SMP_DATA_DEPTH,
	parameter int CODE_DEPTH = `SMP_CODE_DEPTH
)(
	input  wire logic          mclk_in,      // System clock.
	input  wire logic          rst_in,       // Asynchronous reset, active high.
	smp_link_if.device         link,         // Programming link.
	input  wire logic [10:0]   cpu_addr_in,  // Normal-operation read address.
	input  wire logic          cpu_code_in,  // High reads code memory, low data memory.
	output logic [7:0]         cpu_data_out, // Byte read in normal operation.
	output logic               prog_mode_out,// Programming mode is active.
	output logic               ready_out     // Status ready bit.
);
	typedef struct packed {
		smp_dev_st_t st;
		logic [1:0]  s_hv, s_ld, s_di, s_ck;
		logic        ck_d;
		logic        mode;
		logic [31:0] sh_in;
		logic [31:0] sh_out;
		logic [1:0]  pulses;
		logic [`SMP_CNT_W-1:0] cnt;
		logic        sdo;
		logic        ready;
		logic [7:0]  cpu_q;
	} smp_dev_t;
	smp_dev_t r, next_r;
	logic [7:0] data_mem [DATA_DEPTH];
	logic [7:0] code_mem [CODE_DEPTH];
	logic [7:0] rd_byte;
	logic       wr_data, wr_code;
	logic       ck_rise;
	logic [10:0] cmd_addr;
	// Command address field, common to both memories.
	assign cmd_addr = r.sh_in[`SMP_ADDR_HI:`SMP_ADDR_LO]; // RL18 RL22
	assign ck_rise = r.s_ck[1] & ~r.ck_d;
	// Read mux over the selected memory for the current command.
	always_comb
	begin
		rd_byte = 8'h00;
		if (r.sh_in[`SMP_BIT_CODE_SEL]) // RL16
			rd_byte = code_mem[cmd_addr];
		else if (r.sh_in[`SMP_BIT_DATA_SEL]) // RL15
			rd_byte = data_mem[cmd_addr];
	end
	// Write strobes fire once, as the busy count reaches SMP_BUSY_CYC and the response is latched.
	assign wr_data = (r.st == SMP_DEV_EXEC) && (r.cnt == `SMP_CNT_W'(`SMP_BUSY_CYC))
		&& !r.sh_in[`SMP_BIT_READ] && r.sh_in[`SMP_BIT_DATA_SEL]; // RL17 RL1
	assign wr_code = (r.st == SMP_DEV_EXEC) && (r.cnt == `SMP_CNT_W'(`SMP_BUSY_CYC))
		&& !r.sh_in[`SMP_BIT_READ] && r.sh_in[`SMP_BIT_CODE_SEL]; // RL17 RL1
	// Memory arrays, shared by the link and normal operation at one address map.
	always_ff @(posedge mclk_in)
	begin
		if (wr_data)
			data_mem[cmd_addr] <= r.sh_in[`SMP_DATA_HI:`SMP_DATA_LO]; // RL22
		if (wr_code)
			code_mem[cmd_addr] <= r.sh_in[`SMP_DATA_HI:`SMP_DATA_LO];
	end
	// Next-state logic for synchronisers, shifting and execution.
	always_comb
	begin
		next_r = r;
		next_r.s_hv = {r.s_hv[0], link.hv_mode};
		next_r.s_ld = {r.s_ld[0], link.load};
		next_r.s_di = {r.s_di[0], link.sdi};
		next_r.s_ck = {r.s_ck[0], link.sclk}; // RL2
		next_r.ck_d = r.s_ck[1];
		next_r.cpu_q = cpu_code_in ? code_mem[cpu_addr_in] : data_mem[cpu_addr_in];
		if (r.s_hv[1] && !r.mode)
		begin
			next_r.mode = 1'b1; // RL3
			next_r.st = SMP_DEV_IDLE;
			next_r.sdo = 1'b1;
		end
		if (r.mode)
		begin
			unique case (r.st)
				SMP_DEV_IDLE:
				begin
					if (r.s_ld[1]) // RL4
						next_r.st = SMP_DEV_SHIFT;
				end
				SMP_DEV_SHIFT:
				begin
					if (ck_rise && r.s_ld[1])
					begin
						next_r.sh_in = {r.sh_in[30:0], r.s_di[1]}; // RL5
						next_r.sh_out = {r.sh_out[30:0], 1'b0}; // RL6
					end
					next_r.sdo = r.sh_out[31]; // RL6 RL7
					if (!r.s_ld[1])
					begin
						next_r.st = SMP_DEV_EXEC; // RL8
						next_r.pulses = 2'd0;
						next_r.cnt = '0;
					end
				end
				SMP_DEV_EXEC:
				begin
					if (ck_rise && r.pulses != 2'd2)
						next_r.pulses = r.pulses + 2'd1;
					if (r.pulses != 2'd0)
						next_r.sdo = 1'b0; // RL9
					if (r.pulses == 2'd2)
					begin
						next_r.cnt = r.cnt + `SMP_CNT_W'(1);
						if (r.cnt == `SMP_CNT_W'(`SMP_BUSY_CYC))
						begin
							next_r.sh_out[31:19] = 13'h0000;
							next_r.sh_out[`SMP_ADDR_HI:`SMP_ADDR_LO] = cmd_addr; // RL20
							next_r.sh_out[`SMP_DATA_HI:`SMP_DATA_LO] =
								r.sh_in[`SMP_BIT_READ] ? rd_byte // RL13 RL21
								: r.sh_in[`SMP_DATA_HI:`SMP_DATA_LO];
							next_r.ready = 1'b1; // RL10
							next_r.st = SMP_DEV_DONE;
						end
					end
				end
				SMP_DEV_DONE:
				begin
					next_r.sdo = 1'b1; // RL11
					if (r.s_ld[1]) // RL12
					begin
						next_r.st = SMP_DEV_SHIFT;
						next_r.ready = 1'b0;
					end
				end
			endcase
		end
	end
	// State register.
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			r <= '0;
			r.st <= SMP_DEV_IDLE;
			r.sdo <= 1'b1;
		end
		else
			r <= next_r;
	end
	assign link.sdo = r.sdo;
	assign cpu_data_out = r.cpu_q;
	assign prog_mode_out = r.mode;
	assign ready_out = r.ready;
endmodule : smp_device

// >>> hdl/smp_programmer.sv
// Programmer end of the serial memory programming port, with an APB slave for orders.
// Assumes an APB master on mclk_in; makes the link clock by dividing mclk_in.
`timescale 1ns/1ps
`include "smp_map.svh"
module smp_programmer
	import smp_pkg::*;
(
	input  wire logic        mclk_in,      // System clock.
	input  wire logic        rst_in,       // Asynchronous reset, active high.
	input  wire logic        psel_in,      // APB select.
	input  wire logic        penable_in,   // APB enable.
	input  wire logic        pwrite_in,    // APB direction.
	input  wire logic [3:0]  paddr_in,     // APB byte address.
	input  wire logic [31:0] pwdata_in,    // APB write data.
	output logic [31:0]      prdata_out,   // APB read data.
	output logic             pready_out,   // APB ready.
	output logic             pslverr_out,  // APB error on unmapped address.
	smp_link_if.programmer   link          // Programming link.
);
	typedef struct packed {
		smp_prg_st_t st;
		logic [1:0]  s_do;
		logic        hv, ld, di, ck;
		logic [31:0] cmd, rsp;
		logic [5:0]  bits;
		logic [2:0]  div;
		logic        busy;
		logic [31:0] prdata;
		logic        pready, pslverr;
	} smp_prg_t;
	smp_prg_t r, next_r;
	logic tick;
	assign tick = (r.div == 3'(`SMP_HALF_CYC - 1));
	// Link sequencing and APB slave: 0x0 command, 0x4 response, 0x8 status.
	always_comb
	begin
		next_r = r;
		next_r.s_do = {r.s_do[0], link.sdo};
		next_r.div = tick ? 3'd0 : r.div + 3'd1;
		next_r.pready = 1'b0;
		next_r.pslverr = 1'b0;
		if (psel_in && !penable_in)
		begin
			next_r.pready = 1'b1;
			next_r.prdata = 32'h00000000;
			unique case (paddr_in)
				4'h0: next_r.prdata = 32'h00000000;
				4'h4: next_r.prdata = r.rsp;
				4'h8: next_r.prdata = {31'h00000000, r.busy};
				default: next_r.pslverr = 1'b1;
			endcase
		end
		// A command write takes effect only at the edge that completes the transfer.
		// The divider restarts so the device sees the strobe well before the first clock.
		if (psel_in && penable_in && r.pready && pwrite_in && paddr_in == 4'h0 && !r.busy)
		begin
			next_r.cmd = pwdata_in & 32'h3107_FFFF; // RL14
			next_r.di = 1'b0; // RL14 RL5
			next_r.div = 3'd0;
			next_r.busy = 1'b1;
			next_r.hv = 1'b1; // RL3
			next_r.st = SMP_PRG_SHIFT;
			next_r.bits = 6'd0;
			next_r.ld = 1'b1; // RL4
		end
		if (tick)
		begin
			unique case (r.st)
				SMP_PRG_IDLE: next_r.ck = 1'b0;
				SMP_PRG_SHIFT:
				begin
					if (!r.ck)
					begin
						next_r.ck = r.bits != 6'd32;
						if (r.bits == 6'd32)
						begin
							next_r.ld = 1'b0; // RL8
							next_r.st = SMP_PRG_LOW;
							next_r.bits = 6'd0;
						end
					end
					else
					begin
						next_r.ck = 1'b0;
						next_r.rsp = {r.rsp[30:0], r.s_do[1]}; // RL6
						next_r.cmd = {r.cmd[30:0], 1'b0};
						next_r.di = r.cmd[30]; // RL5
						next_r.bits = r.bits + 6'd1;
					end
				end
				SMP_PRG_LOW: next_r.st = SMP_PRG_PULSE;
				SMP_PRG_PULSE:
				begin
					next_r.ck = !r.ck;
					if (r.ck)
						next_r.bits = r.bits + 6'd1;
					if (r.ck && r.bits == 6'd1)
						next_r.st = SMP_PRG_WAIT; // RL8
				end
				SMP_PRG_WAIT:
					if (r.s_do[1]) // RL12
						next_r.st = SMP_PRG_RISE;
				SMP_PRG_RISE:
				begin
					next_r.busy = 1'b0;
					next_r.st = SMP_PRG_IDLE;
				end
				default: next_r.st = SMP_PRG_IDLE;
			endcase
		end
	end
	// State register.
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			r <= '0;
		else
			r <= next_r;
	end
	assign link.hv_mode = r.hv;
	assign link.load = r.ld;
	assign link.sdi = r.di;
	assign link.sclk = r.ck;
	assign prdata_out = r.prdata;
	assign pready_out = r.pready;
	assign pslverr_out = r.pslverr;
endmodule : smp_programmer

// >>> tb/smp_link_props.sv
// Checker for the programming link wires between the two design ends.
// Assumes tb instantiates it beside the link interface; one clock domain.
`timescale 1ns/1ps
module smp_link_props (
	input wire logic mclk_in, // System clock.
	input wire logic rst_in,  // Reset, active high.
	input wire logic hv_mode, // Entry level on the strobe.
	input wire logic load,    // Strobe at logic level.
	input wire logic sdi,     // Data into the device.
	input wire logic sdo,     // Data out of the device.
	input wire logic sclk     // Link clock.
);
	logic [1:0] n_rise;
	logic       sclk_q;

	// Counts link clock rises while the strobe is low, saturating at three.
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			n_rise <= 2'h0;
			sclk_q <= 1'h0;
		end
		else
		begin
			sclk_q <= sclk;
			if (load)
				n_rise <= 2'h0;
			else if (sclk && !sclk_q && n_rise != 2'h3)
				n_rise <= n_rise + 2'h1;
		end
	end

	// All properties run on the system clock and rest during reset.
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (rst_in);

	busy_cycle_a: assert property ($fell(load) |-> ##[1:40] !sdo ##[1:40] sdo)
		else $error("busy handshake did not go low and back high");
	busy_hold_a: assert property (!load && $fell(sdo) |=> !sdo [*8])
		else $error("busy ended too early");
	two_pulses_a: assert property (n_rise <= 2'h2)
		else $error("more than two clocks with strobe low");
	sclk_half_a: assert property ($rose(sclk) |=> sclk [*3] ##1 !sclk)
		else $error("link clock high time wrong");
	sdi_steady_a: assert property ($rose(sclk) |-> $stable(sdi))
		else $error("serial input moved at clock rise");
	hv_entry_a: assert property ($rose(load) |-> hv_mode)
		else $error("strobe raised without entry level");
	load_wait_a: assert property ($rose(load) |-> sdo)
		else $error("strobe raised while device busy");
	load_edge_a: assert property ($changed(load) |-> !sclk)
		else $error("strobe moved while link clock high");
endmodule : smp_link_props

// >>> tb/tb.sv
// Self-checking bench joining programmer and device over the link.
// Assumes the design files and smp_map.svh are compiled first.
`timescale 1ns/1ps
module tb;
	logic        mclk = 1'h0;
	logic        rst = 1'h1;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [3:0]  paddr = 4'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [10:0] cpu_addr = 11'h0;
	logic        cpu_code = 1'h0;
	logic [7:0]  cpu_data;
	logic        prog_mode;
	logic        ready;
	logic [7:0]  mem [0:1][0:2047];
	logic [31:0] rd;
	logic [31:0] want;
	logic [31:0] cmd;
	logic        err;
	logic        have = 1'h0;
	integer      seed = 32'h7188;
	integer      n_mismatch = 0;
	integer      compares = 0;

	smp_link_if lnk ();
	smp_device u_smp_device (.mclk_in(mclk), .rst_in(rst), .link(lnk.device),
		.cpu_addr_in(cpu_addr), .cpu_code_in(cpu_code), .cpu_data_out(cpu_data),
		.prog_mode_out(prog_mode), .ready_out(ready));
	smp_programmer u_smp_programmer (.mclk_in(mclk), .rst_in(rst), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .link(lnk.programmer));
	smp_link_props u_props (.mclk_in(mclk), .rst_in(rst), .hv_mode(lnk.hv_mode),
		.load(lnk.load), .sdi(lnk.sdi), .sdo(lnk.sdo), .sclk(lnk.sclk));

	// System clock, 20 ns period.
	always #10 mclk = ~mclk;

	// Compares a value seen with the value expected.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("FAIL %0t saw %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; holds the request until pready is sampled high.
	task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		do @(posedge mclk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	// Response the device owes for a command, from the memory model.
	function automatic logic [31:0] exp_resp(input logic [31:0] c);
		return {13'h0, c[18:8], c[24] ? mem[c[28]][c[18:8]] : c[7:0]};
	endfunction : exp_resp

	// Runs one command and checks the response to the one before it.
	task automatic op(input logic [31:0] c);
		logic [31:0] nxt;
		nxt = exp_resp(c);
		if (!c[24])
			mem[c[28]][c[18:8]] = c[7:0];
		apb(1'h1, 4'h0, c);
		do apb(1'h0, 4'h8, 32'h0); while (rd[0] !== 1'h0);
		chk(ready, 1'h1);
		apb(1'h0, 4'h4, 32'h0);
		if (have)
			chk(rd, want);
		have = 1'h1;
		want = nxt;
	endtask : op

	// Prints the counts and the verdict, then ends the run.
	task automatic print_verdict;
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict

	// Main sequence: write then read back pairs in both memories.
	initial
	begin
		repeat (10) @(posedge mclk);
		rst <= 1'h0;
		@(posedge mclk);
		chk(prog_mode, 1'h0);
		for (int i = 0; i < 8; i++)
		begin
			cmd = $random(seed);
			cmd[29:28] = i[0] ? 2'h1 : 2'h2;
			cmd[24] = 1'h0;
			if (i == 0)
				cmd[18:8] = 11'h0;
			if (i == 7)
				cmd[18:8] = 11'h7FF;
			op(cmd);
			cmd[24] = 1'h1;
			cmd[7:0] = 8'h0;
			op(cmd);
			chk(prog_mode, 1'h1);
			$display("pair %0d done", i);
		end
		op(cmd);
		cpu_addr <= cmd[18:8];
		cpu_code <= cmd[28];
		repeat (3) @(posedge mclk);
		chk(cpu_data, mem[1][11'h7FF]);
		apb(1'h0, 4'hC, 32'h0);
		chk(err, 1'h1);
		$display("normal read and unmapped access done");
		print_verdict;
	end

	// Watchdog well beyond the expected run length.
	initial
	begin
		#400000;
		n_mismatch++;
		print_verdict;
	end
endmodule : tb
